// ### lcd_instr_pkg.sv
// Purpose: constants for the display instruction executor
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes: instruction opcodes are identified by their leading one
package lcd_instr_pkg;
   localparam int CLK_MHZ = 250;
   localparam int EXEC_SHORT_US = 39;
   localparam int EXEC_LONG_US = 1530;
   localparam int BLINK_MS = 370;
   localparam int EXEC_SHORT_CYC = EXEC_SHORT_US * CLK_MHZ;
   localparam int EXEC_LONG_CYC = EXEC_LONG_US * CLK_MHZ;
   localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [6:0] HOME_ADDR = 7'h00;
   localparam int LINE_LEN_TWO = 40;
   localparam int LINE_LEN_FOUR = 20;
   localparam logic [6:0] LINE2_BASE = 7'h40;
   localparam logic [6:0] LINE4_STEP = 7'h20;
   // Register byte offsets
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_ACCESS = 8'h0c;
   localparam logic [7:0] OFS_SHIFT = 8'h10;
   // Control register fields
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_ISET_BIT = 1;
   localparam int CTRL_TWO_LINE_BIT = 2;
   localparam int CTRL_DH_BIT = 3;
   // Access register fields: bit 0 write, bits 2:1 ram select
   localparam logic [1:0] RAM_TEXT = 2'h0;
   localparam logic [1:0] RAM_GLYPH = 2'h1;
   localparam logic [1:0] RAM_ICON = 2'h2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ### lcd_display_instruction_executor.sv
// Purpose: executes display-control instructions of a character LCD controller
// Assumes: instructions and RAM access events arrive over AXI4-Lite
// Notes: text RAM clear is a counted sweep, one location per cycle
`timescale 1ns/10ps
module lcd_display_instruction_executor
   import lcd_instr_pkg::*;
#(
   parameter int EXEC_SHORT = EXEC_SHORT_CYC,
   parameter int EXEC_LONG = EXEC_LONG_CYC,
   parameter int BLINK_PERIOD = BLINK_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic text_ram_we,
   output logic [6:0] text_ram_addr,
   output logic [7:0] text_ram_wdata,
   output logic all_outputs_supply,
   output logic converter_enable,
   output logic ext_data_out,
   output logic ext_frame_out,
   output logic display_blank,
   output logic cursor_visible,
   output logic cursor_cell_all_on,
   output logic cursor_cell_invert,
   output logic segment_order_reverse,
   output logic font_width_six,
   output logic [2:0] glyph_msb_col,
   output logic four_line_mode
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_CLEAR = 2'b10
   } exec_state_e;

   typedef struct packed {
      exec_state_e st;
      logic [31:0] cnt;
      logic [31:0] blink_cnt;
      logic blink_phase;
      logic [6:0] address_counter;
      logic [6:0] clr_addr;
      logic clr_we;
      logic inc_dir;
      logic shift_on_write;
      logic power_down_enable;
      logic seg_rev;
      logic disp_on;
      logic cursor_on;
      logic blink_on;
      logic font6;
      logic invert_en;
      logic four_line;
      logic [3:0] line_scroll_enable;
      logic [3:0] line_shift_enable;
      logic [3:0][5:0] shift_amt;
      logic extension_register_select;
      logic instruction_set_select;
      logic two_line;
      logic shift_scroll_select;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } exec_s;

   exec_s q, d;

   // Six fifths stretch when wide font is on
   function automatic logic [31:0] exec_time(input logic [31:0] base, input logic wide);
      exec_time = wide ? (base * 32'd6) / 32'd5 : base;
   endfunction

   // Address step with line wrap at visible line end
   function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                            input logic four, input logic two);
      logic [6:0] base;
      logic [6:0] off;
      logic [6:0] len;
      base = four ? (a & 7'h60) : (two ? (a & LINE2_BASE) : 7'h00);
      off = a - base;
      len = four ? 7'(LINE_LEN_FOUR) : (two ? 7'(LINE_LEN_TWO) : 7'd80);
      if (up)
         step_addr = (off == len - 7'd1) ? (four ? 7'(base + LINE4_STEP) : (base ^ LINE2_BASE))
                                           & (four ? 7'h7f : (two ? 7'h40 : 7'h00))
                                         : 7'(a + 7'd1);
      else
         step_addr = (off == 7'd0) ? 7'((four ? 7'(base - LINE4_STEP) : (base ^ LINE2_BASE))
                                        + len - 7'd1) & (two || four ? 7'h7f : 7'h7f)
                                   : 7'(a - 7'd1);
      if (!four && !two && !up && a == 7'd0)
         step_addr = 7'd79;
      if (!four && !two && up && a == 7'd79)
         step_addr = 7'd0;
   endfunction

   logic wr_fire;
   logic [7:0] instr;
   logic [3:0] lead;

   always_comb
   begin
      wr_fire = q.aw_got && q.w_got && !q.bvalid;
      instr = q.w_data[7:0];
      lead = 4'd0;
      for (int i = 0; i < 8; i++)
         if (instr[i])
            lead = 4'(i + 1);
   end

   always_comb
   begin
      d = q;
      d.clr_we = 1'b0;
      if (!q.aw_got && s_axi_awvalid)
      begin
         d.aw_got = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (!q.w_got && s_axi_wvalid)
      begin
         d.w_got = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;
      // Periodic blink / inversion phase
      if (q.blink_cnt >= 32'(BLINK_PERIOD - 1))
      begin
         d.blink_cnt = 32'd0;
         d.blink_phase = !q.blink_phase;
      end
      else
         d.blink_cnt = q.blink_cnt + 32'd1;
      case (q.st)
         ST_EXEC:
            if (q.cnt <= 32'd1)
               d.st = ST_IDLE;
            else
               d.cnt = q.cnt - 32'd1;
         ST_CLEAR:
         begin
            d.clr_we = 1'b1;
            d.clr_addr = 7'(q.clr_addr + 7'd1);
            if (q.clr_addr == 7'h7f)
               d.st = ST_EXEC;
            if (q.cnt > 32'd1)
               d.cnt = q.cnt - 32'd1;
         end
         default:
            ;
      endcase
      if (wr_fire)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = AXI_OKAY;
         if (q.aw_addr == OFS_INSTR && q.st == ST_IDLE && q.w_strb0)
         begin
            d.st = ST_EXEC;
            d.cnt = exec_time(32'(EXEC_SHORT), q.font6);
            case (lead)
               4'd1:
               begin
                  d.address_counter = HOME_ADDR;
                  d.inc_dir = 1'b1;
                  for (int i = 0; i < 4; i++)
                     d.shift_amt[i] = 6'd0;
                  d.clr_addr = 7'd0;
                  d.st = ST_CLEAR;
                  d.cnt = exec_time(32'(EXEC_LONG), q.font6);
               end
               4'd2:
                  if (q.extension_register_select)
                     d.power_down_enable = instr[0];
                  else
                  begin
                     d.address_counter = HOME_ADDR;
                     for (int i = 0; i < 4; i++)
                        d.shift_amt[i] = 6'd0;
                     d.cnt = exec_time(32'(EXEC_LONG), q.font6);
                  end
               4'd3:
                  if (q.extension_register_select)
                     d.seg_rev = instr[0];
                  else
                  begin
                     d.inc_dir = instr[1];
                     d.shift_on_write = instr[0];
                  end
               4'd4:
                  if (q.extension_register_select)
                  begin
                     d.font6 = instr[2];
                     d.invert_en = instr[1];
                     d.four_line = instr[0];
                  end
                  else
                  begin
                     d.disp_on = instr[2];
                     d.cursor_on = instr[1];
                     d.blink_on = instr[0];
                  end
               4'd5:
                  if (q.extension_register_select)
                  begin
                     if (q.shift_scroll_select)
                        d.line_shift_enable = instr[3:0];
                     else
                        d.line_scroll_enable = instr[3:0];
                  end
                  else if (!instr[3])
                     d.address_counter = step_addr(q.address_counter, instr[2],
                                                   q.four_line, q.two_line);
                  else
                     for (int i = 0; i < 4; i++)
                        if (q.shift_scroll_select && q.line_shift_enable[i])
                           d.shift_amt[i] = instr[2] ? 6'(q.shift_amt[i] - 6'd1)
                                                     : 6'(q.shift_amt[i] + 6'd1);
               default:
                  ;
            endcase
         end
         else if (q.aw_addr == OFS_CTRL)
         begin
            d.extension_register_select = q.w_data[CTRL_EXT_BIT];
            d.instruction_set_select = q.w_data[CTRL_ISET_BIT];
            d.two_line = q.w_data[CTRL_TWO_LINE_BIT];
            if (q.w_data[CTRL_ISET_BIT])
               d.shift_scroll_select = q.w_data[CTRL_DH_BIT];
         end
         else if (q.aw_addr == OFS_ACCESS && q.st == ST_IDLE)
         begin
            d.address_counter = q.inc_dir ? 7'(q.address_counter + 7'd1)
                                          : 7'(q.address_counter - 7'd1);
            if (q.w_data[0] && q.shift_on_write && q.w_data[2:1] == RAM_TEXT)
               for (int i = 0; i < 4; i++)
                  if (q.line_shift_enable[i])
                     d.shift_amt[i] = q.inc_dir ? 6'(q.shift_amt[i] + 6'd1)
                                                : 6'(q.shift_amt[i] - 6'd1);
            d.st = ST_EXEC;
            d.cnt = exec_time(32'(EXEC_SHORT), q.font6);
         end
         else if (q.aw_addr == OFS_INSTR || q.aw_addr == OFS_ACCESS)
            d.bresp = AXI_SLVERR;
         else
            d.bresp = AXI_SLVERR;
      end
      if (s_axi_arvalid && !q.rvalid)
      begin
         d.rvalid = 1'b1;
         d.rresp = AXI_OKAY;
         case (s_axi_araddr)
            OFS_STATUS: d.rdata = {22'h0, q.power_down_enable, q.inc_dir,
                                   q.st != ST_IDLE, q.address_counter};
            OFS_CTRL: d.rdata = {28'h0, q.shift_scroll_select, q.two_line,
                                 q.instruction_set_select, q.extension_register_select};
            OFS_SHIFT: d.rdata = {q.shift_amt[3], q.shift_amt[2], 2'h0,
                                  q.shift_amt[1], 2'h0, q.shift_amt[0],
                                  q.line_scroll_enable};
            default:
            begin
               d.rdata = 32'h0;
               d.rresp = AXI_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         q <= '0;
         q.inc_dir <= 1'b1;
         q.instruction_set_select <= 1'b1;
      end
      else
         q <= d;
   end

   assign s_axi_awready = !q.aw_got;
   assign s_axi_wready = !q.w_got;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign text_ram_we = q.clr_we;
   assign text_ram_addr = q.clr_addr - 7'd1;
   assign text_ram_wdata = SPACE_CODE;
   assign all_outputs_supply = q.power_down_enable;
   assign converter_enable = !q.power_down_enable;
   assign ext_data_out = q.power_down_enable;
   assign ext_frame_out = 1'b0;
   assign display_blank = !q.disp_on || q.power_down_enable;
   assign cursor_visible = q.cursor_on && !q.invert_en;
   assign cursor_cell_all_on = q.cursor_on && q.blink_on && !q.invert_en
                               && q.blink_phase;
   assign cursor_cell_invert = q.invert_en && q.blink_phase;
   assign segment_order_reverse = q.seg_rev;
   assign font_width_six = q.font6;
   assign glyph_msb_col = q.font6 ? 3'd5 : 3'd4;
   assign four_line_mode = q.four_line;

   a_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (q.st == ST_EXEC && q.cnt > 32'd1) |=> q.st != ST_IDLE)
      else $error("busy dropped early");
   a_clear_dir: assert property (@(posedge clk_sys) disable iff (rst)
      (q.st == ST_CLEAR) |-> q.inc_dir && q.address_counter == HOME_ADDR)
      else $error("clear state wrong");
   a_pd_ext: assert property (@(posedge clk_sys) disable iff (rst)
      q.power_down_enable |-> ext_data_out && !ext_frame_out && !converter_enable)
      else $error("power down outputs wrong");
   a_dh_guard: assert property (@(posedge clk_sys) disable iff (rst)
      !(wr_fire && q.aw_addr == OFS_CTRL && q.w_data[CTRL_ISET_BIT])
      |=> $stable(q.shift_scroll_select))
      else $error("shift select changed");
   a_inv_over: assert property (@(posedge clk_sys) disable iff (rst)
      q.invert_en |-> !cursor_cell_all_on && !cursor_visible)
      else $error("cursor shown in inversion");
   a_glyph_col: assert property (@(posedge clk_sys) disable iff (rst)
      font_width_six |-> glyph_msb_col == 3'd5)
      else $error("glyph column wrong");
   a_access_step: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_fire && q.aw_addr == OFS_ACCESS && q.st == ST_IDLE && q.inc_dir)
      |=> q.address_counter == 7'($past(q.address_counter) + 7'd1))
      else $error("address step wrong");
   a_seg_order: assert property (@(posedge clk_sys) disable iff (rst)
      segment_order_reverse == q.seg_rev)
      else $error("segment order wrong");
   c_clear: cover property (@(posedge clk_sys) q.st == ST_CLEAR);
   c_pd: cover property (@(posedge clk_sys) q.power_down_enable);
   c_shift: cover property (@(posedge clk_sys) q.shift_amt[0] != 6'd0);
endmodule

// ### lcd_host_model.sv
// Purpose: host side master that issues instructions over AXI4-Lite
// Assumes: one write and one read at most in flight
// Notes: released address and data lines show inverted values
`timescale 1ns/10ps
module lcd_host_model
   import lcd_instr_pkg::*;
(
   input wire logic clk_sys,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done)
      begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done)
      begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic idle();
      logic [31:0] s;
      logic [1:0] r;
      s = 32'h80;
      while (s[7] !== 1'b0)
         rd(OFS_STATUS, s, r);
   endtask
   // Busy polled before every instruction or RAM access
   task automatic cmd(input logic [7:0] a, input logic [7:0] c);
      logic [1:0] r;
      idle();
      @(posedge clk_sys);
      wr(a, {24'h0, c}, r);
   endtask
endmodule

// ### lcd_display_instruction_executor_tb.sv
// Purpose: self-checking bench for the display instruction executor
// Assumes: shortened execution and blink counts
// Notes: expected address and shift amounts are tracked by the bench
`timescale 1ns/10ps
module lcd_display_instruction_executor_tb
   import lcd_instr_pkg::*;
();
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic text_ram_we, all_outputs_supply, converter_enable, ext_data_out, ext_frame_out;
   logic display_blank, cursor_visible, cursor_cell_all_on, cursor_cell_invert;
   logic segment_order_reverse, font_width_six, four_line_mode;
   logic [6:0] text_ram_addr;
   logic [7:0] text_ram_wdata;
   logic [2:0] glyph_msb_col;
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 32190;
   int clr_cnt = 0;
   bit fill_bad = 0;
   logic [31:0] d, r;
   logic [1:0] rs;
   logic [6:0] ac;
   logic [7:0] codes [5] = '{8'h14, 8'h14, 8'h10, 8'h18, 8'h1c};

   lcd_display_instruction_executor #(.EXEC_SHORT(20), .EXEC_LONG(300), .BLINK_PERIOD(50))
      u_lcd_display_instruction_executor (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .text_ram_we, .text_ram_addr,
      .text_ram_wdata, .all_outputs_supply, .converter_enable, .ext_data_out, .ext_frame_out,
      .display_blank, .cursor_visible, .cursor_cell_all_on, .cursor_cell_invert,
      .segment_order_reverse, .font_width_six, .glyph_msb_col, .four_line_mode);
   lcd_host_model u_lcd_host_model (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (text_ram_we === 1'b1)
      begin
         clr_cnt <= clr_cnt + 1;
         if (text_ram_wdata !== SPACE_CODE || text_ram_addr !== 7'(clr_cnt))
            fill_bad <= 1'b1;
      end

   function automatic logic [6:0] step(input logic [6:0] a, input logic inc);
      return inc ? a + 7'h01 : a - 7'h01;
   endfunction
   function automatic logic [6:0] right(input logic [6:0] a, input logic four);
      if (four)
         return (a[4:0] == 5'h13) ? {a[6:5] + 2'h1, 5'h00} : a + 7'h01;
      return (a == 7'h27) ? 7'h40 : a + 7'h01;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic ins(input logic [7:0] c);
      u_lcd_host_model.cmd(OFS_INSTR, c);
      u_lcd_host_model.idle();
   endtask
   task automatic acc(input logic [1:0] ram, input logic w);
      u_lcd_host_model.cmd(OFS_ACCESS, {5'h0, ram, w});
      u_lcd_host_model.idle();
   endtask
   task automatic ctl(input logic [3:0] v);
      u_lcd_host_model.wr(OFS_CTRL, {28'h0, v}, rs);
   endtask
   task automatic chk_ac();
      u_lcd_host_model.rd(OFS_STATUS, d, rs);
      chk({25'h0, d[6:0]}, {25'h0, ac});
   endtask
   // Lines one and two enabled, line three never
   task automatic sh(input logic [5:0] e);
      u_lcd_host_model.rd(OFS_SHIFT, d, rs);
      chk({4'h0, d[3:0], 2'h0, d[9:4], 2'h0, d[17:12], 2'h0, d[25:20]},
          {4'h0, 4'h3, 2'h0, e, 2'h0, e, 8'h0});
   endtask
   task automatic toggles(input bit inv);
      logic s0;
      int n;
      s0 = inv ? cursor_cell_invert : cursor_cell_all_on;
      n = 0;
      while (n < 120 && (inv ? cursor_cell_invert : cursor_cell_all_on) === s0)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk_bit(n < 120, 1'b1);
   endtask
   task automatic stop_test();
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      stop_test();
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      u_lcd_host_model.rd(OFS_STATUS, d, rs);
      chk(d, 32'h100);
      chk_bit(display_blank, 1'b1);
      chk_bit(converter_enable, 1'b1);
      u_lcd_host_model.rd(8'h14, d, rs);
      chk({d[31:2], rs}, {30'h0, AXI_SLVERR});
      ctl(4'h8);
      u_lcd_host_model.rd(OFS_CTRL, d, rs);
      chk({28'h0, d[3:0]}, 32'h0);
      ctl(4'ha);
      u_lcd_host_model.rd(OFS_CTRL, d, rs);
      chk({28'h0, d[3:0]}, 32'ha);
      ins(8'h0f);
      chk({30'h0, display_blank, cursor_visible}, 32'h1);
      toggles(1'b0);
      ins(8'h0c);
      chk_bit(cursor_visible, 1'b0);
      ctl(4'hb);
      for (int v = 0; v < 8; v++)
      begin
         ins(8'h08 | 8'(v));
         chk({27'h0, font_width_six, four_line_mode, glyph_msb_col},
             {27'h0, v[2], v[0], v[2] ? 3'h5 : 3'h4});
      end
      ins(8'h0a);
      toggles(1'b1);
      ins(8'h08);
      ins(8'h07);
      chk_bit(segment_order_reverse, 1'b1);
      ins(8'h03);
      chk({28'h0, all_outputs_supply, converter_enable, ext_data_out, ext_frame_out},
          32'ha);
      ins(8'h02);
      chk({30'h0, all_outputs_supply, converter_enable}, 32'h1);
      ctl(4'ha);
      ins(8'h04);
      u_lcd_host_model.rd(OFS_STATUS, d, rs);
      chk({30'h0, segment_order_reverse, d[8]}, 32'h2);
      u_lcd_host_model.cmd(OFS_INSTR, 8'h01);
      u_lcd_host_model.wr(OFS_INSTR, 32'h02, rs);
      chk({30'h0, rs}, {30'h0, AXI_SLVERR});
      u_lcd_host_model.idle();
      chk(clr_cnt, 128);
      chk_bit(fill_bad, 1'b0);
      u_lcd_host_model.rd(OFS_STATUS, d, rs);
      chk({23'h0, d[8:0]}, 32'h100);
      ac = 7'h00;
      for (int i = 0; i < 12; i++)
      begin
         if (i == 6)
            ins(8'h04);
         r = $random(seed);
         acc((r[2:1] == 2'h3) ? RAM_ICON : r[2:1], r[0]);
         ac = step(ac, i < 6);
         chk_ac();
      end
      ins(8'h06);
      foreach (codes[i])
      begin
         ins(codes[i]);
         if (!codes[i][3])
            ac = step(ac, codes[i][2]);
         chk_ac();
      end
      ctl(4'h3);
      ins(8'h13);
      ctl(4'hb);
      ins(8'h13);
      ctl(4'ha);
      ins(8'h07);
      acc(RAM_TEXT, 1'b1);
      sh(6'h01);
      acc(RAM_TEXT, 1'b0);
      acc(RAM_GLYPH, 1'b1);
      sh(6'h01);
      ac = ac + 7'h03;
      ins(8'h1c);
      sh(6'h00);
      chk_ac();
      ins(8'h18);
      sh(6'h01);
      ins(8'h02);
      ac = 7'h00;
      sh(6'h00);
      chk_ac();
      ins(8'h05);
      acc(RAM_TEXT, 1'b1);
      ac = step(ac, 1'b0);
      sh(6'h3f);
      chk_ac();
      ctl(4'hb);
      ins(8'h08);
      ctl(4'he);
      ins(8'h01);
      ac = 7'h00;
      repeat (40)
      begin
         ins(8'h14);
         ac = right(ac, 1'b0);
      end
      chk_ac();
      ctl(4'hf);
      ins(8'h09);
      ctl(4'he);
      ins(8'h02);
      ac = 7'h00;
      repeat (21)
      begin
         ins(8'h14);
         ac = right(ac, 1'b1);
      end
      chk_ac();
      stop_test();
   end
endmodule
